/* tsc_defs.svh */
`ifndef TSC_DEFS_SVH
`define TSC_DEFS_SVH

// ---------------------------------------------------------------------------
// Register byte offsets
// ---------------------------------------------------------------------------
`define TSC_REG_CTRL        12'h000
`define TSC_REG_STATUS      12'h004
`define TSC_REG_ACQ_CFG     12'h008
`define TSC_REG_ACQ_COUNT   12'h00c
`define TSC_REG_ACQ_DELAY   12'h010
`define TSC_REG_ACQ_PERIOD  12'h014
`define TSC_REG_TRN_CFG     12'h018
`define TSC_REG_TRN_COUNT   12'h01c
`define TSC_REG_TRN_DELAY   12'h020
`define TSC_REG_TRN_PERIOD  12'h024
`define TSC_REG_BUS_TRIG    12'h028
`define TSC_REG_AUTO_SRC    12'h02c

// ---------------------------------------------------------------------------
// Field positions
// ---------------------------------------------------------------------------
`define TSC_CTRL_START_ACQ  0
`define TSC_CTRL_START_TRN  1
`define TSC_CTRL_ABORT_ACQ  2
`define TSC_CTRL_ABORT_TRN  3
`define TSC_CFG_TYPE_LSB    0
`define TSC_CFG_SRC_LSB     4
`define TSC_CFG_INF_BIT     8
`define TSC_BUS_ACQ_BIT     0
`define TSC_BUS_TRN_BIT     1

// ---------------------------------------------------------------------------
// Limits and reset values
// ---------------------------------------------------------------------------
`define TSC_COUNT_MIN       1
`define TSC_COUNT_MAX       100000
`define TSC_COUNT_RST       17'h00001
`define TSC_DELAY_RST       32'h00000000
`define TSC_PERIOD_RST      32'h000001f4
`define TSC_AUTO_COUNT      17'h00001
`define TSC_DIO_PINS        7

`endif

/* tsc_pkg.sv */
package tsc_pkg;

   typedef enum logic [1:0]
   {
      TSC_TYPE_AUTO   = 2'b00,
      TSC_TYPE_SYNC   = 2'b01,
      TSC_TYPE_TIMER  = 2'b10,
      TSC_TYPE_MANUAL = 2'b11
   } tsc_type_t;

   typedef enum logic [3:0]
   {
      TSC_SRC_AUTO  = 4'h0,
      TSC_SRC_BUS   = 4'h1,
      TSC_SRC_TIMER = 4'h2,
      TSC_SRC_INTERNAL_BUS_LINE_ONE  = 4'h3,
      TSC_SRC_INTERNAL_BUS_LINE_TWO  = 4'h4,
      TSC_SRC_LAN   = 4'h5,
      TSC_SRC_DIO1  = 4'h6,
      TSC_SRC_DIO7  = 4'hc,
      TSC_SRC_TIN   = 4'hd
   } tsc_src_t;

   typedef enum logic [1:0]
   {
      TSC_ST_IDLE  = 2'b00,
      TSC_ST_WAIT  = 2'b01,
      TSC_ST_DELAY = 2'b10,
      TSC_ST_FIRE  = 2'b11
   } tsc_state_t;

endpackage

/* tsc_action.sv */
`timescale 1ns/1ns
`include "tsc_defs.svh"

module tsc_action
#(
   parameter int CNT_W = 17,
   parameter int TIM_W = 32
)
(
   input  wire logic                 core_clk,
   input  wire logic                 rst,
   input  wire logic                 start,
   input  wire logic                 abort,
   input  wire tsc_pkg::tsc_type_t   trigType,
   input  wire tsc_pkg::tsc_src_t    trigSrc,
   input  wire logic                 infiniteCount,
   input  wire logic [CNT_W-1:0]     countCfg,
   input  wire logic [TIM_W-1:0]     delayCfg,
   input  wire logic [TIM_W-1:0]     periodCfg,
   input  wire tsc_pkg::tsc_src_t    autoSrc,
   input  wire logic                 busTrig,
   input  wire logic                 internalBusLineOne,
   input  wire logic                 internalBusLineTwo,
   input  wire logic                 lanEvent,
   input  wire logic [`TSC_DIO_PINS-1:0] digitalIoPin,
   input  wire logic                 rearTriggerInput,
   output logic                      actionPulse,
   output logic                      busy,
   output logic [CNT_W-1:0]          remaining
);
   import tsc_pkg::*;

   initial
   begin
      if (CNT_W < 17 || TIM_W < 2)
         $error("tsc_action: widths too small");
   end

   tsc_state_t       state_r;
   tsc_src_t         effSrc;
   logic [TIM_W-1:0] effDelay;
   logic [CNT_W-1:0] effCount;
   logic [TIM_W-1:0] delayCnt_r;
   logic [TIM_W-1:0] periodCnt_r;
   logic             timerTick;
   logic             srcLevel;
   logic             srcLevel_r;
   logic             srcEvent;
   logic             infinite_r;
   logic [3:0]       dioIdx;

   // -------------------------------------------------------------------
   // Type presets
   // -------------------------------------------------------------------
   always_comb
   begin
      effSrc   = trigSrc;
      effDelay = delayCfg;
      effCount = countCfg;
      case (trigType)
         TSC_TYPE_AUTO:
         begin
            effSrc   = TSC_SRC_AUTO;              // see R14
            effDelay = '0;                        // see R14
            effCount = CNT_W'(`TSC_AUTO_COUNT);   // see R2
         end
         TSC_TYPE_SYNC:  effSrc = TSC_SRC_AUTO;   // see R14
         TSC_TYPE_TIMER: effSrc = TSC_SRC_TIMER;  // see R14
         default:        effSrc = trigSrc;
      endcase
      if (effSrc == TSC_SRC_AUTO)
         effSrc = autoSrc;                        // see R6
   end

   // -------------------------------------------------------------------
   // Periodic timer
   // -------------------------------------------------------------------
   always_ff @(posedge core_clk)
   begin
      if (rst || state_r == TSC_ST_IDLE || timerTick)
         periodCnt_r <= '0;
      else
         periodCnt_r <= periodCnt_r + 1'b1;
   end
   assign timerTick = (periodCnt_r + 1'b1 >= periodCfg); // see R5

   // -------------------------------------------------------------------
   // Source selection and edge detect
   // -------------------------------------------------------------------
   assign dioIdx = effSrc - TSC_SRC_DIO1;

   always_comb
   begin
      srcLevel = 1'b0;
      case (effSrc)
         TSC_SRC_BUS:   srcLevel = busTrig;             // see R7
         TSC_SRC_TIMER: srcLevel = timerTick;           // see R5
         TSC_SRC_INTERNAL_BUS_LINE_ONE:  srcLevel = internalBusLineOne;  // see R8
         TSC_SRC_INTERNAL_BUS_LINE_TWO:  srcLevel = internalBusLineTwo;  // see R8
         TSC_SRC_LAN:   srcLevel = lanEvent;            // see R11
         TSC_SRC_TIN:   srcLevel = rearTriggerInput;    // see R10
         default:
            if (effSrc >= TSC_SRC_DIO1 && effSrc <= TSC_SRC_DIO7)
               srcLevel = digitalIoPin[dioIdx[2:0]];    // see R9
      endcase
   end

   always_ff @(posedge core_clk)
   begin
      if (rst)
         srcLevel_r <= 1'b0;
      else
         srcLevel_r <= srcLevel;
   end
   // Timer ticks are single pulses, others rising edges
   assign srcEvent = (effSrc == TSC_SRC_TIMER) ? timerTick
                   : (srcLevel && !srcLevel_r);

   // -------------------------------------------------------------------
   // Sequencer
   // -------------------------------------------------------------------
   always_ff @(posedge core_clk)
   begin
      if (rst)
      begin
         state_r    <= TSC_ST_IDLE;
         remaining  <= '0;
         delayCnt_r <= '0;
         infinite_r <= 1'b0;
      end
      else if (abort)
         state_r <= TSC_ST_IDLE;
      else
      begin
         case (state_r)
            TSC_ST_IDLE:
               if (start)
               begin
                  remaining  <= effCount;                // see R1
                  infinite_r <= infiniteCount
                                && trigType != TSC_TYPE_AUTO;
                  state_r    <= TSC_ST_WAIT;
               end
            TSC_ST_WAIT:
               if (srcEvent)
               begin
                  delayCnt_r <= effDelay;                // see R4
                  state_r    <= TSC_ST_DELAY;
               end
            TSC_ST_DELAY:
               if (delayCnt_r == '0)
                  state_r <= TSC_ST_FIRE;
               else
                  delayCnt_r <= delayCnt_r - 1'b1;       // see R4
            TSC_ST_FIRE:
            begin
               if (!infinite_r)
                  remaining <= remaining - 1'b1;         // see R15
               if (!infinite_r && remaining == CNT_W'(1))
                  state_r <= TSC_ST_IDLE;                // see R15
               else
                  state_r <= TSC_ST_WAIT;
            end
            default: state_r <= TSC_ST_IDLE;
         endcase
      end
   end

   assign actionPulse = (state_r == TSC_ST_FIRE);
   assign busy        = (state_r != TSC_ST_IDLE);

endmodule // tsc_action

/* tsc_trigger_ctrl.sv */
// Notes on behaviour
// R1 - Count 1 to 100000 or infinite
// R2 - Automatic type sets count itself
// R3 - Separate settings for measure and source
// R4 - Wait programmed delay after trigger event
// R5 - Timer source pulses every period
// R6 - Automatic source picks best fitting source; engines take it from autoSrc_r instead, timer after reset
// R7 - Bus command acts as trigger event
// R8 - Internal bus line one or two
// R9 - Digital I/O pin 1 to 7
// R10 - Rear trigger input source
// R11 - LAN event source
// R12 - Simplified settings override detailed configuration
// R13 - User matches source and measure counts
// R14 - Type presets for delay and source
// R15 - Count down, stop at zero unless infinite
`timescale 1ns/1ns
`include "tsc_defs.svh"

module tsc_trigger_ctrl
#(
   parameter int TIM_W = 32
)
(
   input  wire logic                     core_clk,
   input  wire logic                     rst,
   input  wire logic                     psel,
   input  wire logic                     penable,
   input  wire logic                     pwrite,
   input  wire logic [11:0]              paddr,
   input  wire logic [31:0]              pwdata,
   output logic [31:0]                   prdata,
   output logic                          pready,
   output logic                          pslverr,
   input  wire logic                     internalBusLineOne,
   input  wire logic                     internalBusLineTwo,
   input  wire logic                     lanEvent,
   input  wire logic [`TSC_DIO_PINS-1:0] digitalIoPin,
   input  wire logic                     rearTriggerInput,
   output logic                          acquireTrigger,
   output logic                          transientTrigger
);
   import tsc_pkg::*;

   localparam int CNT_W = 17;

   initial
   begin
      if (TIM_W < 2 || TIM_W > 32)
         $error("tsc_trigger_ctrl: TIM_W must be 2..32");
   end

   // -------------------------------------------------------------------
   // Configuration registers
   // -------------------------------------------------------------------
   logic [1:0]       acqType_r;
   logic [3:0]       acqSrc_r;
   logic             acqInf_r;
   logic [CNT_W-1:0] acqCount_r;
   logic [TIM_W-1:0] acqDelay_r;
   logic [TIM_W-1:0] acqPeriod_r;
   logic [1:0]       trnType_r;
   logic [3:0]       trnSrc_r;
   logic             trnInf_r;
   logic [CNT_W-1:0] trnCount_r;
   logic [TIM_W-1:0] trnDelay_r;
   logic [TIM_W-1:0] trnPeriod_r;
   logic [3:0]       autoSrc_r;
   logic [1:0]       busTrig_r;
   logic [3:0]       ctrlPulse_r;
   logic             acqBusy;
   logic             trnBusy;
   logic [CNT_W-1:0] acqRemain;
   logic [CNT_W-1:0] trnRemain;
   logic             acqFire;
   logic             trnFire;

   logic             wrEn;
   logic             rdEn;
   logic             addrOk;
   logic             badData;
   logic [CNT_W-1:0] wrCount;
   logic [31:0]      rdData;

   assign wrEn    = psel && penable && pwrite;
   assign rdEn    = psel && penable && !pwrite;
   assign wrCount = pwdata[CNT_W-1:0];
   assign pready  = 1'b1;

   // -------------------------------------------------------------------
   // Address decode
   // -------------------------------------------------------------------
   always_comb
   begin
      addrOk = 1'b1;
      if (paddr == `TSC_REG_CTRL)            addrOk = 1'b1;
      else if (paddr == `TSC_REG_STATUS)     addrOk = 1'b1;
      else if (paddr == `TSC_REG_ACQ_CFG)    addrOk = 1'b1;
      else if (paddr == `TSC_REG_ACQ_COUNT)  addrOk = 1'b1;
      else if (paddr == `TSC_REG_ACQ_DELAY)  addrOk = 1'b1;
      else if (paddr == `TSC_REG_ACQ_PERIOD) addrOk = 1'b1;
      else if (paddr == `TSC_REG_TRN_CFG)    addrOk = 1'b1;
      else if (paddr == `TSC_REG_TRN_COUNT)  addrOk = 1'b1;
      else if (paddr == `TSC_REG_TRN_DELAY)  addrOk = 1'b1;
      else if (paddr == `TSC_REG_TRN_PERIOD) addrOk = 1'b1;
      else if (paddr == `TSC_REG_BUS_TRIG)   addrOk = 1'b1;
      else if (paddr == `TSC_REG_AUTO_SRC)   addrOk = 1'b1;
      else                                   addrOk = 1'b0;
   end

   // Out-of-range counts are refused, register keeps old value
   always_comb
   begin
      badData = 1'b0;
      if ((paddr == `TSC_REG_ACQ_COUNT || paddr == `TSC_REG_TRN_COUNT)
          && (pwdata < 32'(`TSC_COUNT_MIN)
              || pwdata > 32'(`TSC_COUNT_MAX)))              // see R1
         badData = 1'b1;
   end

   assign pslverr = psel && penable && (!addrOk || (pwrite && badData));

   // -------------------------------------------------------------------
   // Measurement action settings
   // -------------------------------------------------------------------
   always_ff @(posedge core_clk)
   begin
      if (rst)
      begin
         acqType_r   <= TSC_TYPE_AUTO;
         acqSrc_r    <= TSC_SRC_AUTO;
         acqInf_r    <= 1'b0;
         acqCount_r  <= `TSC_COUNT_RST;
         acqDelay_r  <= TIM_W'(`TSC_DELAY_RST);
         acqPeriod_r <= TIM_W'(`TSC_PERIOD_RST);
      end
      else if (wrEn && !badData)
      begin
         if (paddr == `TSC_REG_ACQ_CFG)                      // see R3
         begin
            acqType_r <= pwdata[`TSC_CFG_TYPE_LSB +: 2];
            acqSrc_r  <= pwdata[`TSC_CFG_SRC_LSB +: 4];
            acqInf_r  <= pwdata[`TSC_CFG_INF_BIT];
         end
         else if (paddr == `TSC_REG_ACQ_COUNT)  acqCount_r  <= wrCount;
         else if (paddr == `TSC_REG_ACQ_DELAY)  acqDelay_r  <= pwdata[TIM_W-1:0];
         else if (paddr == `TSC_REG_ACQ_PERIOD) acqPeriod_r <= pwdata[TIM_W-1:0];
      end
   end

   // -------------------------------------------------------------------
   // Source-output action settings
   // -------------------------------------------------------------------
   always_ff @(posedge core_clk)
   begin
      if (rst)
      begin
         trnType_r   <= TSC_TYPE_AUTO;
         trnSrc_r    <= TSC_SRC_AUTO;
         trnInf_r    <= 1'b0;
         trnCount_r  <= `TSC_COUNT_RST;
         trnDelay_r  <= TIM_W'(`TSC_DELAY_RST);
         trnPeriod_r <= TIM_W'(`TSC_PERIOD_RST);
      end
      else if (wrEn && !badData)
      begin
         if (paddr == `TSC_REG_TRN_CFG)                      // see R3
         begin
            trnType_r <= pwdata[`TSC_CFG_TYPE_LSB +: 2];
            trnSrc_r  <= pwdata[`TSC_CFG_SRC_LSB +: 4];
            trnInf_r  <= pwdata[`TSC_CFG_INF_BIT];
         end
         else if (paddr == `TSC_REG_TRN_COUNT)  trnCount_r  <= wrCount;
         else if (paddr == `TSC_REG_TRN_DELAY)  trnDelay_r  <= pwdata[TIM_W-1:0];
         else if (paddr == `TSC_REG_TRN_PERIOD) trnPeriod_r <= pwdata[TIM_W-1:0];
      end
   end

   // -------------------------------------------------------------------
   // Auto-source choice, command pulses
   // -------------------------------------------------------------------
   always_ff @(posedge core_clk)
   begin
      if (rst)
         autoSrc_r <= TSC_SRC_TIMER;
      else if (wrEn && paddr == `TSC_REG_AUTO_SRC)
         autoSrc_r <= pwdata[3:0];                           // see R6
   end

   always_ff @(posedge core_clk)
   begin
      if (rst)
      begin
         busTrig_r   <= 2'h0;
         ctrlPulse_r <= 4'h0;
      end
      else
      begin
         busTrig_r   <= 2'h0;
         ctrlPulse_r <= 4'h0;
         if (wrEn && paddr == `TSC_REG_BUS_TRIG)
            busTrig_r <= pwdata[1:0];                        // see R7
         if (wrEn && paddr == `TSC_REG_CTRL)
            ctrlPulse_r <= pwdata[3:0];
      end
   end

   // -------------------------------------------------------------------
   // Read data
   // -------------------------------------------------------------------
   always_comb
   begin
      rdData = 32'h0;
      if (paddr == `TSC_REG_STATUS)
         rdData = {30'h0, trnBusy, acqBusy};
      else if (paddr == `TSC_REG_ACQ_CFG)
         rdData = {23'h0, acqInf_r, acqSrc_r, 2'h0, acqType_r};
      else if (paddr == `TSC_REG_ACQ_COUNT)
         rdData = 32'(acqCount_r);
      else if (paddr == `TSC_REG_ACQ_DELAY)
         rdData = 32'(acqDelay_r);
      else if (paddr == `TSC_REG_ACQ_PERIOD)
         rdData = 32'(acqPeriod_r);
      else if (paddr == `TSC_REG_TRN_CFG)
         rdData = {23'h0, trnInf_r, trnSrc_r, 2'h0, trnType_r};
      else if (paddr == `TSC_REG_TRN_COUNT)
         rdData = 32'(trnCount_r);
      else if (paddr == `TSC_REG_TRN_DELAY)
         rdData = 32'(trnDelay_r);
      else if (paddr == `TSC_REG_TRN_PERIOD)
         rdData = 32'(trnPeriod_r);
      else if (paddr == `TSC_REG_AUTO_SRC)
         rdData = {28'h0, autoSrc_r};
   end

   always_ff @(posedge core_clk)
   begin
      if (rst)
         prdata <= 32'h0;
      else if (psel && !penable && !pwrite)
         prdata <= rdData;
   end

   // -------------------------------------------------------------------
   // Action engines
   // -------------------------------------------------------------------
   // Type presets inside the engines override the detailed settings        see R12
   tsc_action #(.CNT_W(CNT_W), .TIM_W(TIM_W)) acqEngine
   (
      .core_clk           (core_clk),
      .rst                (rst),
      .start              (ctrlPulse_r[`TSC_CTRL_START_ACQ]),
      .abort              (ctrlPulse_r[`TSC_CTRL_ABORT_ACQ]),
      .trigType           (tsc_type_t'(acqType_r)),
      .trigSrc            (tsc_src_t'(acqSrc_r)),
      .infiniteCount      (acqInf_r),
      .countCfg           (acqCount_r),
      .delayCfg           (acqDelay_r),
      .periodCfg          (acqPeriod_r),
      .autoSrc            (tsc_src_t'(autoSrc_r)),
      .busTrig            (busTrig_r[`TSC_BUS_ACQ_BIT]),
      .internalBusLineOne (internalBusLineOne),
      .internalBusLineTwo (internalBusLineTwo),
      .lanEvent           (lanEvent),
      .digitalIoPin       (digitalIoPin),
      .rearTriggerInput   (rearTriggerInput),
      .actionPulse        (acqFire),
      .busy               (acqBusy),
      .remaining          (acqRemain)
   );

   tsc_action #(.CNT_W(CNT_W), .TIM_W(TIM_W)) trnEngine
   (
      .core_clk           (core_clk),
      .rst                (rst),
      .start              (ctrlPulse_r[`TSC_CTRL_START_TRN]),
      .abort              (ctrlPulse_r[`TSC_CTRL_ABORT_TRN]),
      .trigType           (tsc_type_t'(trnType_r)),
      .trigSrc            (tsc_src_t'(trnSrc_r)),
      .infiniteCount      (trnInf_r),
      .countCfg           (trnCount_r),
      .delayCfg           (trnDelay_r),
      .periodCfg          (trnPeriod_r),
      .autoSrc            (tsc_src_t'(autoSrc_r)),
      .busTrig            (busTrig_r[`TSC_BUS_TRN_BIT]),
      .internalBusLineOne (internalBusLineOne),
      .internalBusLineTwo (internalBusLineTwo),
      .lanEvent           (lanEvent),
      .digitalIoPin       (digitalIoPin),
      .rearTriggerInput   (rearTriggerInput),
      .actionPulse        (trnFire),
      .busy               (trnBusy),
      .remaining          (trnRemain)
   );

   always_ff @(posedge core_clk)
   begin
      if (rst)
      begin
         acquireTrigger   <= 1'b0;
         transientTrigger <= 1'b0;
      end
      else
      begin
         acquireTrigger   <= acqFire;
         transientTrigger <= trnFire;
      end
   end

endmodule // tsc_trigger_ctrl

/* tsc_checker_assertions.sv */
`timescale 1ns/1ns
`include "tsc_defs.svh"
module tsc_checker
(
   input wire logic        core_clk,
   input wire logic        rst,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic        pready,
   input wire logic        pslverr,
   input wire logic        acquireTrigger,
   input wire logic        transientTrigger
);
   logic access, cntWr, bad;
   assign access = psel && penable;
   assign cntWr  = access && pwrite && (paddr == 12'h00c || paddr == 12'h01c);
   assign bad    = pwdata < `TSC_COUNT_MIN || pwdata > `TSC_COUNT_MAX;
   default clocking dc @(posedge core_clk);
   endclocking
   default disable iff (rst);
   ready_high_a:
      assert property (pready)
      else $error("ready low");
   err_phase_a:
      assert property (pslverr |-> access)
      else $error("error outside access");
   unmapped_a:
      assert property (access && paddr > 12'h02c |-> pslverr)
      else $error("unmapped access accepted");
   count_range_a:
      assert property (cntWr && bad |-> pslverr)
      else $error("bad count accepted");
   count_ok_a:
      assert property (cntWr && !bad |-> !pslverr)
      else $error("good count refused");
   acq_pulse_a:
      assert property ($rose(acquireTrigger) |=> !acquireTrigger)
      else $error("acquire pulse too long");
   trn_pulse_a:
      assert property ($rose(transientTrigger) |=> !transientTrigger)
      else $error("source pulse too long");
   abort_quiet_a:
      assert property (access && pwrite && paddr == 12'h000 && pwdata[2]
         && !pwdata[0] |-> ##3 !acquireTrigger [*3])
      else $error("pulse after abort");
   ctrl_read_a:
      assert property (psel && !penable && !pwrite && paddr == 12'h000
         |=> prdata == 32'h0)
      else $error("control reads nonzero");
   cover property (acquireTrigger);
   cover property (transientTrigger);
   cover property (pslverr);
endmodule // tsc_checker

bind tsc_trigger_ctrl tsc_checker i_chk (.core_clk, .rst, .psel, .penable,
   .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .acquireTrigger,
   .transientTrigger);

/* tsc_src_model.sv */
`timescale 1ns/1ns
`include "tsc_defs.svh"
module tsc_src_model
(
   input  wire logic                 core_clk,
   input  wire tsc_pkg::tsc_src_t    pick,
   input  wire logic                 kick,
   output logic                      internalBusLineOne,
   output logic                      internalBusLineTwo,
   output logic                      lanEvent,
   output logic [`TSC_DIO_PINS-1:0]  digitalIoPin,
   output logic                      rearTriggerInput
);
   import tsc_pkg::*;
   tsc_src_t   cur;
   logic [1:0] hold = 2'h0;
   logic       on;
   // Picked line stays high three cycles
   always @(posedge core_clk)
   begin
      if (kick)
      begin
         cur  <= pick;
         hold <= 2'h3;
      end
      else if (hold != 2'h0)
         hold <= hold - 2'h1;
   end
   assign on                 = hold != 2'h0;
   assign internalBusLineOne = on && cur == TSC_SRC_INTERNAL_BUS_LINE_ONE;
   assign internalBusLineTwo = on && cur == TSC_SRC_INTERNAL_BUS_LINE_TWO;
   assign lanEvent           = on && cur == TSC_SRC_LAN;
   assign rearTriggerInput   = on && cur == TSC_SRC_TIN;
   assign digitalIoPin = (on && cur >= TSC_SRC_DIO1 && cur <= TSC_SRC_DIO7)
      ? 7'h01 << (cur - TSC_SRC_DIO1) : 7'h00;
endmodule // tsc_src_model

/* trigger_source_controller_bench.sv */
`timescale 1ns/1ns
`include "tsc_defs.svh"
module trigger_source_controller_bench;
   import tsc_pkg::*;
   logic        core_clk, rst, psel, penable, pwrite, kick, pready, pslverr;
   logic        err, acquireTrigger, transientTrigger, lanEvent;
   logic        internalBusLineOne, internalBusLineTwo, rearTriggerInput;
   logic [6:0]  digitalIoPin;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   tsc_src_t    pick;
   int          n_mismatch, check_count, n0, n1, nP[2];
   longint      tP[2], lP[2], t0, d0;
   logic [11:0] ra[9] = '{12'h008, 12'h00c, 12'h010, 12'h014, 12'h018,
                          12'h01c, 12'h024, 12'h02c, 12'h000};
   logic [31:0] rv[9] = '{32'h0, 32'h1, 32'h0, 32'h1f4, 32'h0, 32'h1,
                          32'h1f4, 32'h2, 32'h0};
   tsc_trigger_ctrl i_dut (.core_clk, .rst, .psel, .penable, .pwrite, .paddr,
      .pwdata, .prdata, .pready, .pslverr, .internalBusLineOne,
      .internalBusLineTwo, .lanEvent, .digitalIoPin, .rearTriggerInput,
      .acquireTrigger, .transientTrigger);
   tsc_src_model i_src (.core_clk, .pick, .kick, .internalBusLineOne,
      .internalBusLineTwo, .lanEvent, .digitalIoPin, .rearTriggerInput);
   initial
   begin
      core_clk = 1'b0;
      forever #10 core_clk = ~core_clk;
   end
   initial
   begin
      #400000;
      n_mismatch++;
      summarize();
   end
   always @(posedge core_clk)
   begin
      if (acquireTrigger === 1'b1)
         note(0);
      if (transientTrigger === 1'b1)
         note(1);
   end
   // ------
   // Tasks
   // ------
   task automatic note(input int a);
      nP[a]++;
      lP[a] = tP[a];
      tP[a] = $time;
   endtask
   task automatic check(input logic [31:0] seen, exp);
      check_count++;
      if (seen !== exp)
      begin
         n_mismatch++;
         $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic summarize;
      $display("checks %0d mismatches %0d", check_count, n_mismatch);
      if (n_mismatch == 0 && check_count > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   task automatic wt(input int n);
      repeat (n) @(posedge core_clk);
   endtask
   task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d);
      @(posedge core_clk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= d;
      @(posedge core_clk);
      penable <= 1'b1;
      @(posedge core_clk);
      while (pready !== 1'b1)
         @(posedge core_clk);
      rd = prdata;
      err = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask
   function automatic logic [31:0] cw(tsc_type_t t, tsc_src_t s, logic infinite_count);
      return {23'h0, infinite_count, s, 2'b00, t};
   endfunction
   task automatic arm(input int a, input logic [31:0] c, n, d, p);
      logic [11:0] b;
      b = a ? 12'h018 : 12'h008;
      apb(b, 1'b1, c);
      apb(b + 12'h004, 1'b1, n);
      apb(b + 12'h008, 1'b1, d);
      apb(b + 12'h00c, 1'b1, p);
      apb(12'h000, 1'b1, 32'h1 << a);
   endtask
   task automatic fire(input int a, input tsc_src_t s);
      if (s == TSC_SRC_BUS)
         apb(12'h028, 1'b1, 32'h1 << a);
      else
      begin
         pick <= s;
         kick <= 1'b1;
         @(posedge core_clk);
         kick <= 1'b0;
      end
      wt(10);
   endtask
   // ------
   // Sequence
   // ------
   initial
   begin
      {rst, psel, penable, pwrite, kick, paddr, pwdata} = '1;
      {psel, penable, pwrite, kick, paddr, pwdata} = '0;
      pick = TSC_SRC_AUTO;
      wt(5);
      rst <= 1'b0;
      for (int i = 0; i < 9; i++)
      begin
         apb(ra[i], 1'b0, 32'h0);
         check(rd, rv[i]);
      end
      apb(12'h030, 1'b0, 32'h0);
      check({rd[30:0], err}, 1);
      apb(12'h00c, 1'b1, 32'h0);
      check(err, 1);
      apb(12'h00c, 1'b1, 32'h186a1);
      check(err, 1);
      apb(12'h00c, 1'b1, 32'h186a0);
      apb(12'h00c, 1'b0, 32'h0);
      check({err, rd[30:0]}, 32'h186a0);
      for (int a = 0; a < 2; a++)
      begin
         for (int s = 1; s < 14; s++)
         begin
            n0 = nP[a];
            n1 = nP[1 - a];
            arm(a, cw(TSC_TYPE_MANUAL, tsc_src_t'(s), 1'b0), 1, 0, 500);
            if (s != 2)
               fire(a, tsc_src_t'(s));
            else
               apb(12'h000, 1'b1, 32'h4 << a);
            check(nP[a] - n0, s != 2);
            check(nP[1 - a] - n1, 0);
         end
         n0 = nP[a];
         arm(a, cw(TSC_TYPE_MANUAL, TSC_SRC_DIO7, 1'b0), 1, 0, 500);
         fire(a, TSC_SRC_DIO1);
         fire(a, TSC_SRC_DIO7);
         check(nP[a] - n0, 1);
         arm(a, cw(TSC_TYPE_MANUAL, TSC_SRC_TIN, 1'b0), 1, 0, 500);
         t0 = $time;
         fire(a, TSC_SRC_TIN);
         d0 = tP[a] - t0;
         arm(a, cw(TSC_TYPE_MANUAL, TSC_SRC_TIN, 1'b0), 1, 6, 500);
         t0 = $time;
         fire(a, TSC_SRC_TIN);
         wt(10);
         check((tP[a] - t0 - d0) / 20, 6);
         n0 = nP[a];
         arm(a, cw(TSC_TYPE_TIMER, TSC_SRC_BUS, 1'b0), 3, 0, 8);
         wt(60);
         check(nP[a] - n0, 3);
         check((tP[a] - lP[a]) / 20, 8);
         n0 = nP[a];
         arm(a, cw(TSC_TYPE_AUTO, TSC_SRC_BUS, 1'b0), 5, 9, 8);
         wt(60);
         check(nP[a] - n0, 1);
         apb(12'h02c, 1'b1, 32'h1);
         n0 = nP[a];
         arm(a, cw(TSC_TYPE_SYNC, TSC_SRC_TIN, 1'b0), 2, 0, 8);
         fire(a, TSC_SRC_TIN);
         fire(a, TSC_SRC_BUS);
         fire(a, TSC_SRC_BUS);
         check(nP[a] - n0, 2);
         apb(12'h02c, 1'b1, 32'h2);
         n0 = nP[a];
         arm(a, cw(TSC_TYPE_MANUAL, TSC_SRC_TIMER, 1'b1), 1, 0, 4);
         wt(40);
         check(nP[a] - n0 > 3, 1);
         apb(12'h004, 1'b0, 32'h0);
         check(rd[a], 1);
         apb(12'h000, 1'b1, 32'h4 << a);
         apb(12'h004, 1'b0, 32'h0);
         check(rd[a], 0);
      end
      summarize();
   end
endmodule // trigger_source_controller_bench
